// ---- inc/capb_pkg.sv ----
// Constants for the second capture channel control block
`default_nettype none

package capb_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;

  ////////////////////////////////////////////////////////////////////////
  // Control field positions
  localparam int CHAN_ON_BIT = 15;
  localparam int SHORT_DET_BIT = 11;
  localparam int RESAMPLE_BIT = 10;
  localparam int SCALE_BIT = 8;
  localparam int REPEAT_BIT = 7;
  localparam int ONE_PIC_BIT = 6;
  localparam int SECOND_FIELD_BIT = 5;
  localparam int FIRST_FIELD_BIT = 4;
  localparam int FMT_LSB = 0;
  localparam int FMT_W = 2;

  // Control reset value and writable bits
  localparam logic [31:0] CTRL_RESET = 32'h0000_0030;
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000_8DF3;

  // Capture format codes
  localparam logic [1:0] FMT_EMBEDDED_8BIT = 2'h0;
  localparam logic [1:0] FMT_UNFORMATTED_8BIT = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // Status field positions
  localparam int ST_SHORT_BIT = 0;
  localparam int ST_ACTIVE_BIT = 1;
  localparam int ST_FIELD_BIT = 2;
  localparam int ST_COUNT_LSB = 8;
  localparam int ST_COUNT_W = 8;
  localparam logic [31:0] STATUS_W1C_MASK = 32'h0000_0001;

  ////////////////////////////////////////////////////////////////////////
  // Counts and reset values
  localparam int RAW_BLOCK_BYTES_DEF = 256;
  localparam int MIN_FIELD_BYTES_DEF = 1024;
  localparam int FIELD_COUNT_W_DEF = 24;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_CR = 2'h2;
  localparam logic [31:0] READ_RESET = 32'h0000_0000;
  localparam logic [10:0] PIN_SYNC_RESET = 11'h400;

  // Capture sequencer states
  typedef enum logic [1:0] {seq_idle, seq_wait_frame, seq_in_frame, seq_raw_block} seq_t;

endpackage : capb_pkg

`default_nettype wire

// ---- core/chroma_resample.sv ----
// Chroma rate converter for the capture byte stream
`default_nettype none

module chroma_resample
  import capb_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic restart,
  input wire logic resample_on,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_chroma,
  input wire logic in_cr,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_chroma
);

  logic [7:0] prev_cb_reg;
  logic [7:0] prev_cr_reg;
  logic have_cb_reg;
  logic have_cr_reg;
  logic [7:0] prev_sel;
  logic have_sel;
  logic [8:0] sum;

  assign prev_sel = in_cr ? prev_cr_reg : prev_cb_reg;
  assign have_sel = in_cr ? have_cr_reg : have_cb_reg;
  assign sum = {1'b0, prev_sel} + {1'b0, in_data};

  ////////////////////////////////////////////////////////////////////////
  // Previous chroma samples
  always_ff @(posedge clock)
  begin
    if (srst || restart)
    begin
      prev_cb_reg <= 8'h00;
      prev_cr_reg <= 8'h00;
      have_cb_reg <= 1'b0;
      have_cr_reg <= 1'b0;
    end
    else if (in_valid && in_chroma)
    begin
      if (in_cr)
      begin
        prev_cr_reg <= in_data;
        have_cr_reg <= 1'b1;
      end
      else
      begin
        prev_cb_reg <= in_data;
        have_cb_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output stage, midpoint of neighbouring chroma when on
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      out_valid <= 1'b0;
      out_data <= 8'h00;
      out_chroma <= 1'b0;
    end
    else
    begin
      out_valid <= in_valid;
      out_chroma <= in_chroma;
      if (resample_on && in_chroma && have_sel)
        out_data <= sum[8:1];
      else
        out_data <= in_data;
    end
  end

endmodule : chroma_resample

`default_nettype wire

// ---- core/capture_chan_b_ctrl.sv ----
// Second capture channel control register and capture gating
//
// Summary of operation
// - Short field check only when enabled, video
// - Chroma resampled 4:2:2 to 4:2:0 when enabled
// - Reserved bits 9, 3-2 read zero
// - Repeat bit captures continuously, resets to zero
// - One picture bit captures frame or block
// - Second field captured when its bit set
// - First field captured when its bit set
// - Format resets to embedded sync 8-bit
// - Format 2h is raw, video controls ignored
`default_nettype none

module capture_chan_b_ctrl
  import capb_pkg::*;
#(
  parameter int RAW_BLOCK_BYTES = RAW_BLOCK_BYTES_DEF,
  parameter int MIN_FIELD_BYTES = MIN_FIELD_BYTES_DEF,
  parameter int FIELD_COUNT_W = FIELD_COUNT_W_DEF
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [7:0] vid_data_pin,
  input wire logic vid_valid_pin,
  input wire logic vid_field_pin,
  input wire logic vid_vblank_pin,
  output logic [7:0] cap_data,
  output logic cap_valid,
  output logic cap_chroma
);

  if (RAW_BLOCK_BYTES < 2 || MIN_FIELD_BYTES < 1 || FIELD_COUNT_W < 2 || FIELD_COUNT_W > 31
      || MIN_FIELD_BYTES >= (1 << FIELD_COUNT_W) || RAW_BLOCK_BYTES >= (1 << FIELD_COUNT_W))
  begin : g_bad_params
    $error("capture_chan_b_ctrl: unsupported parameter values");
  end

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  localparam logic [FIELD_COUNT_W-1:0] MIN_COUNT = FIELD_COUNT_W'(MIN_FIELD_BYTES);
  localparam logic [FIELD_COUNT_W-1:0] BLOCK_LAST = FIELD_COUNT_W'(RAW_BLOCK_BYTES - 1);
  localparam logic [FIELD_COUNT_W-1:0] COUNT_MAX = {FIELD_COUNT_W{1'b1}};

  logic [31:0] ctrl_reg;
  logic short_seen_reg;
  logic [ST_COUNT_W-1:0] done_count_reg;
  logic [10:0] pin_s1_reg;
  logic [10:0] pin_s2_reg;
  logic vblank_d_reg;
  seq_t seq_reg;
  logic field_capture_reg;
  logic [1:0] phase_reg;
  logic group_reg;
  logic [FIELD_COUNT_W-1:0] field_bytes_reg;
  logic [FIELD_COUNT_W-1:0] block_bytes_reg;

  ////////////////////////////////////////////////////////////////////////
  // Field decode
  logic chan_on, short_on, resample_on, scale_on, repeat_on, one_pic, second_on, first_on;
  logic [1:0] fmt;
  logic fmt_embedded, fmt_raw;
  assign chan_on = ctrl_reg[CHAN_ON_BIT];
  assign short_on = ctrl_reg[SHORT_DET_BIT];
  assign resample_on = ctrl_reg[RESAMPLE_BIT];
  assign scale_on = ctrl_reg[SCALE_BIT];
  assign repeat_on = ctrl_reg[REPEAT_BIT];
  assign one_pic = ctrl_reg[ONE_PIC_BIT];
  assign second_on = ctrl_reg[SECOND_FIELD_BIT];
  assign first_on = ctrl_reg[FIRST_FIELD_BIT];
  assign fmt = ctrl_reg[FMT_LSB +: FMT_W];
  assign fmt_embedded = (fmt == FMT_EMBEDDED_8BIT);
  assign fmt_raw = (fmt == FMT_UNFORMATTED_8BIT);

  ////////////////////////////////////////////////////////////////////////
  // Bus access decode
  logic req, access, wr_ctrl, wr_status;
  logic [31:0] wmask;
  assign req = read | write;
  assign access = req & ~waitrequest;
  assign wmask = lane_mask(byteenable);
  assign wr_ctrl = access & write & (address == CTRL_OFFSET);
  assign wr_status = access & write & (address == STATUS_OFFSET);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      // Blank idles high: no false field end after reset
      pin_s1_reg <= PIN_SYNC_RESET;
      pin_s2_reg <= PIN_SYNC_RESET;
      vblank_d_reg <= 1'b1;
    end
    else
    begin
      pin_s1_reg <= {vid_vblank_pin, vid_field_pin, vid_valid_pin, vid_data_pin};
      pin_s2_reg <= pin_s1_reg;
      vblank_d_reg <= pin_s2_reg[10];
    end
  end

  logic [7:0] vdata;
  logic vvalid, vfield, vblank, field_start, field_end;
  assign vdata = pin_s2_reg[7:0];
  assign vvalid = pin_s2_reg[8];
  assign vfield = pin_s2_reg[9];
  assign vblank = pin_s2_reg[10];
  assign field_start = vblank_d_reg & ~vblank;
  assign field_end = ~vblank_d_reg & vblank;

  ////////////////////////////////////////////////////////////////////////
  // Byte acceptance and scaling
  logic video_take, raw_take, keep_byte, done;
  assign video_take = field_capture_reg & vvalid & ~vblank & chan_on & fmt_embedded;
  assign raw_take = chan_on & fmt_raw & vvalid & (repeat_on | (seq_reg == seq_raw_block));
  assign keep_byte = raw_take | (video_take & ~(scale_on & group_reg));

  always_ff @(posedge clock)
  begin
    if (srst || field_start)
    begin
      phase_reg <= PHASE_RESET;
      group_reg <= 1'b0;
    end
    else if (video_take)
    begin
      phase_reg <= phase_reg + 2'h1;
      if (phase_reg == PHASE_LAST)
        group_reg <= ~group_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field capture gate
  logic pick_field, frame_ok;
  assign pick_field = vfield ? second_on : first_on;
  assign frame_ok = repeat_on | (seq_reg == seq_wait_frame & ~vfield) | (seq_reg == seq_in_frame);

  always_ff @(posedge clock)
  begin
    if (srst || field_end)
      field_capture_reg <= 1'b0;
    else if (field_start)
      field_capture_reg <= chan_on & fmt_embedded & pick_field & frame_ok;
  end

  ////////////////////////////////////////////////////////////////////////
  // Single picture and block sequencer
  always_ff @(posedge clock)
  begin
    if (srst)
      seq_reg <= seq_idle;
    else if (!chan_on)
      seq_reg <= seq_idle;
    else
    begin
      case (seq_reg)
        seq_idle:
          if (one_pic && !done)
            seq_reg <= fmt_raw ? seq_raw_block : (fmt_embedded ? seq_wait_frame : seq_idle);
        seq_wait_frame:
          if (field_start && !vfield)
            seq_reg <= seq_in_frame;
        seq_in_frame:
          if (field_end && vfield)
            seq_reg <= seq_idle;
        seq_raw_block:
          if (raw_take && block_bytes_reg == BLOCK_LAST)
            seq_reg <= seq_idle;
        default:
          seq_reg <= seq_idle;
      endcase
    end
  end

  assign done = chan_on & (((seq_reg == seq_in_frame) & field_end & vfield)
    | ((seq_reg == seq_raw_block) & raw_take & (block_bytes_reg == BLOCK_LAST)));

  always_ff @(posedge clock)
  begin
    if (srst || seq_reg != seq_raw_block)
      block_bytes_reg <= '0;
    else if (raw_take)
      block_bytes_reg <= block_bytes_reg + FIELD_COUNT_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////
  // Short field detection
  always_ff @(posedge clock)
  begin
    if (srst || field_start)
      field_bytes_reg <= '0;
    else if (vvalid && !vblank && field_bytes_reg != COUNT_MAX)
      field_bytes_reg <= field_bytes_reg + FIELD_COUNT_W'(1);
  end

  logic short_event;
  assign short_event = field_end & short_on & chan_on & fmt_embedded & (field_bytes_reg < MIN_COUNT);

  always_ff @(posedge clock)
  begin
    if (srst)
      short_seen_reg <= 1'b0;
    else if (short_event)
      short_seen_reg <= 1'b1;
    else if (wr_status && wmask[ST_SHORT_BIT] && writedata[ST_SHORT_BIT])
      short_seen_reg <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      done_count_reg <= '0;
    else if (done)
      done_count_reg <= done_count_reg + ST_COUNT_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register; settings assumed stable while channel on
  always_ff @(posedge clock)
  begin
    if (srst)
      ctrl_reg <= CTRL_RESET;
    else if (wr_ctrl)
      ctrl_reg <= ((ctrl_reg & ~wmask) | (writedata & wmask)) & CTRL_WRITE_MASK;
    else if (done)
      ctrl_reg[ONE_PIC_BIT] <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle per access
  logic [31:0] status_word;
  always_comb
  begin
    status_word = '0;
    status_word[ST_SHORT_BIT] = short_seen_reg;
    status_word[ST_ACTIVE_BIT] = (seq_reg != seq_idle) | field_capture_reg;
    status_word[ST_FIELD_BIT] = vfield;
    status_word[ST_COUNT_LSB +: ST_COUNT_W] = done_count_reg;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      waitrequest <= 1'b1;
    else
      waitrequest <= ~(req & waitrequest);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      readdata <= READ_RESET;
    else if (read && waitrequest)
    begin
      case (address)
        CTRL_OFFSET: readdata <= ctrl_reg & CTRL_WRITE_MASK;
        STATUS_OFFSET: readdata <= status_word;
        default: readdata <= READ_RESET;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Chroma converter and output stage
  chroma_resample u_resample (
    .clock(clock),
    .srst(srst),
    .restart(field_start),
    .resample_on(resample_on & fmt_embedded),
    .in_valid(keep_byte),
    .in_data(vdata),
    .in_chroma(video_take & ~phase_reg[0]),
    .in_cr(phase_reg == PHASE_CR),
    .out_valid(cap_valid),
    .out_data(cap_data),
    .out_chroma(cap_chroma)
  );

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  a_short_flag_set: assert property (short_event |=> short_seen_reg)
    else $error("short field not flagged");
  a_short_off_quiet: assert property (!short_seen_reg && !(field_end && short_on) |=> !short_seen_reg)
    else $error("short flag set while detection off");
  a_resample_off_pass: assert property (keep_byte && !resample_on |=> cap_data == $past(vdata))
    else $error("chroma altered while resampling off");
  a_reserved_zero: assert property (read && !waitrequest && address == CTRL_OFFSET
    |-> readdata[9] == 1'b0 && readdata[3:2] == 2'h0)
    else $error("reserved bits read nonzero");
  a_scale_drop: assert property (video_take && scale_on && group_reg && !raw_take |=> !cap_valid)
    else $error("half scaling kept a dropped byte");
  a_reset_values: assert property ($past(srst) |-> !repeat_on && fmt == FMT_EMBEDDED_8BIT
    && first_on && second_on && !one_pic)
    else $error("control reset value wrong");
  a_repeat_capture: assert property (field_start && repeat_on && chan_on && fmt_embedded && pick_field
    |=> field_capture_reg)
    else $error("continuous capture missed a field");
  a_picture_done: assert property (done && !(wr_ctrl && writedata[ONE_PIC_BIT]) |=> !one_pic ##1 seq_reg == seq_idle)
    else $error("one picture bit not cleared on completion");
  a_second_skip: assert property (field_start && vfield && !second_on |=> !field_capture_reg)
    else $error("second field captured while disabled");
  a_first_take: assert property (field_start && !vfield && first_on && repeat_on && chan_on && fmt_embedded
    |=> field_capture_reg [*1] ##0 !vblank)
    else $error("first field not captured");
  a_raw_pass: assert property (raw_take |=> cap_valid && !cap_chroma)
    else $error("raw byte not passed");

  c_frame_done: cover property (seq_reg == seq_in_frame ##[1:1000] seq_reg == seq_idle);
  c_raw_block: cover property (seq_reg == seq_raw_block ##[1:1000] done);
  c_short_field: cover property (short_event);
  c_bus_read: cover property (read && !waitrequest && address == STATUS_OFFSET);

endmodule : capture_chan_b_ctrl

`default_nettype wire

// ---- verif/video_source.sv ----
// Behavioural video byte source that feeds the capture pins
`default_nettype none

module video_source
(
  input wire logic clock,
  input wire logic srst,
  input wire logic go,
  input wire logic field_id,
  input wire logic slow,
  input wire logic [7:0] nbytes,
  output logic [7:0] vid_data_pin,
  output logic vid_valid_pin,
  output logic vid_field_pin,
  output logic vid_vblank_pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] idx_reg;
  logic gap_reg;

  ////////////////////////////////////////////////////////////////////////
  // One field: blank falls, bytes, blank rises; idle data toggles
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      vid_vblank_pin <= 1'b1;
      vid_valid_pin <= 1'b0;
      vid_data_pin <= 8'h00;
      vid_field_pin <= 1'b0;
      busy <= 1'b0;
      idx_reg <= 8'h00;
      gap_reg <= 1'b0;
    end
    else if (go && !busy)
    begin
      busy <= 1'b1;
      vid_vblank_pin <= 1'b0;
      vid_field_pin <= field_id;
      idx_reg <= 8'h00;
      gap_reg <= 1'b0;
      vid_data_pin <= ~vid_data_pin;
    end
    else if (busy && idx_reg == nbytes)
    begin
      busy <= 1'b0;
      vid_valid_pin <= 1'b0;
      vid_vblank_pin <= 1'b1;
      vid_data_pin <= ~vid_data_pin;
    end
    else if (busy && !(slow && gap_reg))
    begin
      vid_valid_pin <= 1'b1;
      vid_data_pin <= {idx_reg[3:0], 4'h0};
      idx_reg <= idx_reg + 8'h01;
      gap_reg <= 1'b1;
    end
    else
    begin
      vid_valid_pin <= 1'b0;
      vid_data_pin <= ~vid_data_pin;
      gap_reg <= 1'b0;
    end
  end

endmodule : video_source

`default_nettype wire

// ---- verif/capture_chan_b_ctrl_bench.sv ----
// Self-checking bench for the second capture channel control block
`default_nettype none

module capture_chan_b_ctrl_bench
  import capb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic [3:0] be; logic [31:0] w; logic [31:0] exp;} reg_row_t;
  typedef struct {logic [31:0] cfg; logic fid; logic [7:0] n; logic sl; logic [31:0] cnt;} cap_row_t;

  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic [7:0] vid_data_pin;
  logic vid_valid_pin;
  logic vid_field_pin;
  logic vid_vblank_pin;
  logic [7:0] cap_data;
  logic cap_valid;
  logic cap_chroma;
  logic go = 1'b0;
  logic field_id = 1'b0;
  logic slow = 1'b0;
  logic [7:0] nbytes = 8'h00;
  logic busy;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] cap_q[$];
  logic [31:0] v;
  logic [31:0] cur_cfg = 32'h0000_0030;

  reg_row_t reg_rows [5] = '{
    '{4'hF, 32'hFFFF_7FFF, 32'h0000_0DF3},
    '{4'hF, 32'h0000_0000, 32'h0000_0000},
    '{4'h1, 32'hFFFF_FFFF, 32'h0000_00F3},
    '{4'hF, 32'h0000_020C, 32'h0000_0000},
    '{4'hF, 32'h0000_0C82, 32'h0000_0C82}};

  cap_row_t cap_rows [7] = '{
    '{32'h0000_00B0, 1'b0, 8'h08, 1'b0, 32'h8},
    '{32'h0000_00A0, 1'b0, 8'h08, 1'b0, 32'h0},
    '{32'h0000_00A0, 1'b1, 8'h08, 1'b1, 32'h8},
    '{32'h0000_0090, 1'b1, 8'h08, 1'b0, 32'h0},
    '{32'h0000_0030, 1'b0, 8'h08, 1'b0, 32'h0},
    '{32'h0000_01B0, 1'b0, 8'h10, 1'b0, 32'h8},
    '{32'h0000_0542, 1'b0, 8'h08, 1'b1, 32'h4}};

  always #2 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////
  // Design and video source
  capture_chan_b_ctrl #(.RAW_BLOCK_BYTES(4), .MIN_FIELD_BYTES(8)) dut (
    .clock(clock), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .vid_data_pin(vid_data_pin), .vid_valid_pin(vid_valid_pin),
    .vid_field_pin(vid_field_pin), .vid_vblank_pin(vid_vblank_pin), .cap_data(cap_data),
    .cap_valid(cap_valid), .cap_chroma(cap_chroma));

  video_source src (
    .clock(clock), .srst(srst), .go(go), .field_id(field_id), .slow(slow), .nbytes(nbytes),
    .vid_data_pin(vid_data_pin), .vid_valid_pin(vid_valid_pin), .vid_field_pin(vid_field_pin),
    .vid_vblank_pin(vid_vblank_pin), .busy(busy));

  ////////////////////////////////////////////////////////////////////////
  // Captured byte log and hang limit
  always @(posedge clock)
    if (cap_valid === 1'b1)
      cap_q.push_back(cap_data);

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      err_count++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] got);
    @(posedge clock);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= d;
    byteenable <= be;
    do @(posedge clock); while (waitrequest !== 1'b0);
    got = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic setup(input logic [31:0] cfg);
    logic [31:0] dummy;
    bus(1'b1, CTRL_OFFSET, cur_cfg & 32'hFFFF_7FFF, 4'hF, dummy);
    bus(1'b1, CTRL_OFFSET, cfg, 4'hF, dummy);
    bus(1'b1, CTRL_OFFSET, cfg | 32'h0000_8000, 4'hF, dummy);
    cur_cfg = cfg | 32'h0000_8000;
    cap_q.delete();
  endtask : setup

  task automatic send(input logic fid, input logic [7:0] n, input logic sl);
    @(posedge clock);
    go <= 1'b1;
    field_id <= fid;
    nbytes <= n;
    slow <= sl;
    @(posedge clock);
    go <= 1'b0;
    do @(negedge clock); while (busy === 1'b1);
    repeat (12) @(posedge clock);
  endtask : send

  task complete_run();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    foreach (reg_rows[i])
    begin
      bus(1'b1, CTRL_OFFSET, reg_rows[i].w, reg_rows[i].be, v);
      bus(1'b0, CTRL_OFFSET, 32'h0, 4'hF, v);
      check(v, reg_rows[i].exp);
      $display("register row %0d done", i);
    end
    foreach (cap_rows[i])
    begin
      setup(cap_rows[i].cfg);
      send(cap_rows[i].fid, cap_rows[i].n, cap_rows[i].sl);
      check(32'(cap_q.size()), cap_rows[i].cnt);
      $display("capture row %0d done", i);
    end
    bus(1'b0, CTRL_OFFSET, 32'h0, 4'hF, v);
    check(v, 32'h0000_8502);
    $display("raw block done");
    setup(32'h0000_08B0);
    send(1'b0, 8'h04, 1'b0);
    bus(1'b0, STATUS_OFFSET, 32'h0, 4'hF, v);
    check(v & 32'h0000_0001, 32'h0000_0001);
    bus(1'b1, STATUS_OFFSET, 32'h0000_0001, 4'hF, v);
    setup(32'h0000_00B0);
    send(1'b0, 8'h04, 1'b0);
    bus(1'b0, STATUS_OFFSET, 32'h0, 4'hF, v);
    check(v & 32'h0000_0001, 32'h0000_0000);
    $display("short field done");
    setup(32'h0000_04B0);
    send(1'b0, 8'h08, 1'b0);
    check({24'h0, cap_q[4]}, 32'h0000_0020);
    check({24'h0, cap_q[5]}, 32'h0000_0050);
    check({24'h0, cap_q[6]}, 32'h0000_0040);
    setup(32'h0000_00B0);
    send(1'b0, 8'h08, 1'b0);
    check({24'h0, cap_q[4]}, 32'h0000_0040);
    $display("resample done");
    setup(32'h0000_0070);
    send(1'b0, 8'h04, 1'b0);
    send(1'b1, 8'h04, 1'b0);
    check(32'(cap_q.size()), 32'h8);
    bus(1'b0, CTRL_OFFSET, 32'h0, 4'hF, v);
    check(v, 32'h0000_8030);
    bus(1'b0, STATUS_OFFSET, 32'h0, 4'hF, v);
    check(v & 32'h0000_FF00, 32'h0000_0200);
    $display("single picture done");
    @(posedge clock);
    srst <= 1'b1;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    repeat (2) @(posedge clock);
    bus(1'b0, CTRL_OFFSET, 32'h0, 4'hF, v);
    check(v, 32'h0000_0030);
    bus(1'b0, STATUS_OFFSET, 32'h0, 4'hF, v);
    check(v, 32'h0000_0000);
    bus(1'b1, 4'hC, 32'hFFFF_FFFF, 4'hF, v);
    bus(1'b0, 4'h8, 32'h0, 4'hF, v);
    check(v, 32'h0000_0000);
    bus(1'b0, CTRL_OFFSET, 32'h0, 4'hF, v);
    check(v, 32'h0000_0030);
    $display("reset done");
    complete_run();
  end

endmodule : capture_chan_b_ctrl_bench

`default_nettype wire
